// file: src/amfd_diag.sv
// Diagnosis readout with serial target port for a four-channel amplifier
// Overview of operation
// RULE1 - one-shot mode: first read after setup carries no valid data
// RULE2 - permanent diagnosis runs whether diagnostic cycle enable is 1 or 0
// RULE3 - a bare read returns diagnosis status, no write needed first
// RULE4 - removed permanent fault still reported on the next read
// RULE5 - permanent diagnosis starts by itself when turn-on diagnosis ends
// RULE6 - offset result is not latched; each read shows the live comparison
// RULE7 - host spaces offset reads by one low-frequency period, reads twice
// RULE8 - a write switches the clip pin between clip and offset indication
// RULE9 - host stimulates tweeter check after unmute, reads after cycles
// RULE10 - thermal warning bit in first diagnostic byte near shutdown point
// RULE11 - host reads diagnostics at least twice before judging
// RULE12 - turn-on multiple faults merge into shorted load or ground short
// RULE13 - ground plus supply short shows ground short once, then nothing
// RULE14 - answer only address byte 216; its low bit is direction
// RULE15 - direction 0 writes instruction bytes, 1 reads diagnostic bytes
// RULE16 - writes carry two instruction bytes, reads return four bytes
// RULE17 - first instruction byte bit 7 picks one-shot or repetition
// RULE18 - first diagnostic byte bit 6 is 1 once diagnosis terminated
// RULE19 - second instruction byte bit 5 selects clip pin function
`timescale 1ns/1ps
module amfd_diag (
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire amfd_pkg::amfd_fault_t [3:0] fault_in,
    input wire logic thermal_warn_in,
    input wire logic clip_in,
    input wire logic acq_done,
    output logic [7:0] first_instruction_byte,
    output logic [7:0] second_instruction_byte,
    output logic clip_output_pin
);
    amfd_pkg::amfd_state_t s;
    amfd_pkg::amfd_state_t next_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic rd_start;
    logic [3:0][5:0] ch_bits;
    logic [3:0][2:0] next_latch;
    logic [3:0] next_seen;
    logic [3:0][7:0] db;

    // Edge and frame detection on sampled bus lines
    assign scl_rise = scl_in & ~s.scl_q;
    assign scl_fall = ~scl_in & s.scl_q;
    assign start_c = scl_in & s.scl_q & s.sda_q & ~sda_in;
    assign stop_c = scl_in & s.scl_q & ~s.sda_q & sda_in;
    assign rd_start = scl_fall & (s.st == amfd_pkg::ST_AACK) & s.rw;

    // Per-channel report bits and fault memory
    for (genvar i = 0; i < amfd_pkg::NUM_CH; i++)
    begin : g_ch
        amfd_pkg::amfd_fault_t r;
        logic both;
        logic [2:0] hold;
        logic [3:0] ton;
        logic [3:0] prm;
        assign r = fault_in[i];
        assign both = r.sgnd & r.svcc;
        assign hold = s.latch[i] | {r.sload, r.svcc, r.sgnd};
        // Turn-on merging of simultaneous faults
        assign ton = {r.sload | r.svcc, r.open & ~r.sgnd, r.svcc,
            r.sgnd & ~r.svcc}; // see RULE12
        // Permanent: sticky shorts, live offset, one-time mixed short
        assign prm = {hold[2], s.ib1[amfd_pkg::IB1_OFS_EN] & r.offset,
            hold[1] & ~both, both ? ~s.seen[i] : hold[0]}; // see RULE6 RULE13
        assign ch_bits[i] = {r.cur_low & s.ib2[amfd_pkg::IB2_CUR_EN], s.perm,
            s.perm ? prm : ton};
        // Read consumes history; a fault present now is kept
        assign next_latch[i] = rd_start ? {r.sload, r.svcc, r.sgnd}
            : hold; // see RULE4
        assign next_seen[i] = both & (s.seen[i] | rd_start); // see RULE13
    end

    // Diagnostic byte assembly, zeroed on the invalid one-shot read
    always_comb
    begin
        for (int i = 0; i < amfd_pkg::NUM_CH; i++)
        begin
            db[i] = {2'b00, ch_bits[i]};
        end
        db[0][amfd_pkg::DB1_THERM] = thermal_warn_in; // see RULE10
        db[0][amfd_pkg::DB1_DONE] = s.done; // see RULE18
        db[1][amfd_pkg::DB2_OFS_ACT] = s.ib1[amfd_pkg::IB1_OFS_EN];
        db[1][amfd_pkg::DB2_CUR_ACT] = s.ib2[amfd_pkg::IB2_CUR_EN];
        db[2][amfd_pkg::DB3_DIAG] = s.ib1[amfd_pkg::IB1_DIAG_EN];
        db[2][amfd_pkg::DB3_PLAY] = s.ib2[amfd_pkg::IB2_PLAY];
        if (s.first_pend)
        begin
            db = '0; // see RULE1
        end
    end

    // Next state: bus target, instruction store, diagnosis sequencing
    always_comb
    begin
        next_s = s;
        next_s.scl_q = scl_in;
        next_s.sda_q = sda_in;
        next_s.latch = next_latch;
        next_s.seen = next_seen;
        next_s.clip_pin = s.ib2[amfd_pkg::IB2_PIN_SEL]
            ? |{fault_in[0].offset, fault_in[1].offset,
               fault_in[2].offset, fault_in[3].offset}
            : clip_in; // see RULE8 RULE19
        if (acq_done & s.ib1[amfd_pkg::IB1_DIAG_EN])
        begin
            next_s.done = 1'b1; // see RULE18
            next_s.perm = 1'b1; // see RULE5
        end
        if (scl_rise)
        begin
            unique case (s.st)
                amfd_pkg::ST_ADDR, amfd_pkg::ST_WR:
                begin
                    next_s.sh = {s.sh[6:0], sda_in};
                    next_s.cnt = s.cnt + 4'h1;
                end
                amfd_pkg::ST_RD: next_s.cnt = s.cnt + 4'h1;
                amfd_pkg::ST_RACK: next_s.nack = sda_in;
                default: next_s.cnt = s.cnt;
            endcase
        end
        if (scl_fall)
        begin
            unique case (s.st)
                amfd_pkg::ST_ADDR:
                begin
                    if (s.cnt == amfd_pkg::BIT_LAST)
                    begin
                        // Only our address is acknowledged
                        if (s.sh[7:1] == amfd_pkg::DEV_ADDR) // see RULE14
                        begin
                            next_s.sda_oe = 1'b1;
                            next_s.rw = s.sh[0]; // see RULE15
                            next_s.st = amfd_pkg::ST_AACK;
                        end
                        else
                        begin
                            next_s.st = amfd_pkg::ST_IDLE;
                        end
                    end
                end
                amfd_pkg::ST_AACK:
                begin
                    next_s.cnt = '0;
                    if (s.rw)
                    begin
                        // Bare read snapshots status, no write needed
                        next_s.snap = db; // see RULE3
                        next_s.first_pend = 1'b0; // see RULE1
                        next_s.sh = db[0];
                        next_s.sda_oe = ~db[0][7];
                        next_s.idx = 3'h1;
                        next_s.st = amfd_pkg::ST_RD;
                    end
                    else
                    begin
                        next_s.sda_oe = 1'b0;
                        next_s.idx = '0;
                        next_s.st = amfd_pkg::ST_WR;
                    end
                end
                amfd_pkg::ST_WR:
                begin
                    if (s.cnt == amfd_pkg::BIT_LAST)
                    begin
                        next_s.sda_oe = 1'b1;
                        next_s.st = amfd_pkg::ST_WACK;
                        next_s.idx = s.idx + 3'h1;
                        if (s.idx == '0)
                        begin
                            next_s.ib1 = s.sh; // see RULE16
                        end
                        else if (s.idx == amfd_pkg::IDX_IB2)
                        begin
                            next_s.ib2 = s.sh; // see RULE16
                            // Setup complete: restart or skip turn-on
                            next_s.done = 1'b0;
                            next_s.perm = ~s.ib1[amfd_pkg::IB1_DIAG_EN]; // see RULE2
                            next_s.first_pend = s.ib1[amfd_pkg::IB1_DIAG_EN]
                                & ~s.ib1[amfd_pkg::IB1_TIMING]; // see RULE17
                        end
                    end
                end
                amfd_pkg::ST_WACK:
                begin
                    next_s.sda_oe = 1'b0;
                    next_s.cnt = '0;
                    next_s.st = amfd_pkg::ST_WR;
                end
                amfd_pkg::ST_RD:
                begin
                    if (s.cnt == amfd_pkg::BIT_LAST)
                    begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = amfd_pkg::ST_RACK;
                    end
                    else
                    begin
                        next_s.sh = {s.sh[6:0], 1'b0};
                        next_s.sda_oe = ~s.sh[6];
                    end
                end
                amfd_pkg::ST_RACK:
                begin
                    // Four bytes then release on nack; extra acked reads give 8'h80, as only bit 7 is released
                    if (s.nack)
                    begin
                        next_s.st = amfd_pkg::ST_IDLE;
                    end
                    else
                    begin
                        next_s.sh = s.idx[2] ? 8'h00 : s.snap[s.idx[1:0]]; // see RULE16
                        next_s.sda_oe = s.idx[2] ? 1'b0
                            : ~s.snap[s.idx[1:0]][7];
                        next_s.idx = s.idx[2] ? s.idx : s.idx + 3'h1;
                        next_s.cnt = '0;
                        next_s.st = amfd_pkg::ST_RD;
                    end
                end
                default: next_s.st = s.st;
            endcase
        end
        if (start_c)
        begin
            next_s.st = amfd_pkg::ST_ADDR;
            next_s.cnt = '0;
            next_s.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            next_s.st = amfd_pkg::ST_IDLE;
            next_s.sda_oe = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s <= '0;
            s.st <= amfd_pkg::ST_IDLE;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
            s.ib1 <= amfd_pkg::IB1_RST;
            s.ib2 <= amfd_pkg::IB2_RST;
            s.perm <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sda_out = 1'b0; // Open drain: only pulls low
    assign sda_oe = s.sda_oe;
    assign first_instruction_byte = s.ib1;
    assign second_instruction_byte = s.ib2;
    assign clip_output_pin = s.clip_pin;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence addr_done_s;
        scl_fall && !start_c && !stop_c && s.st == amfd_pkg::ST_ADDR
            && s.cnt == amfd_pkg::BIT_LAST;
    endsequence
    sequence read_open_s;
        rd_start && !start_c && !stop_c;
    endsequence

    addr_match_a: assert property (addr_done_s ##0 s.sh[7:1] == amfd_pkg::DEV_ADDR
        |=> sda_oe && s.st == amfd_pkg::ST_AACK) // see RULE14
        else $error("own address not acknowledged");
    addr_other_a: assert property (addr_done_s ##0 s.sh[7:1] != amfd_pkg::DEV_ADDR
        |=> !sda_oe && s.st == amfd_pkg::ST_IDLE) // see RULE14
        else $error("foreign address acknowledged");
    dir_route_a: assert property (read_open_s |=> s.st == amfd_pkg::ST_RD
        && s.sh == s.snap[0]) // see RULE15
        else $error("read direction not routed to read");
    first_read_a: assert property (read_open_s ##0 s.first_pend
        |=> s.snap[0] == 8'h00 ##1 !s.first_pend) // see RULE1
        else $error("one-shot first read not blanked");
    auto_perm_a: assert property (acq_done && s.ib1[amfd_pkg::IB1_DIAG_EN]
        |=> s.perm && s.done) // see RULE5
        else $error("permanent diagnosis not started");
    thermal_a: assert property (read_open_s ##0 !s.first_pend
        |=> s.snap[0][amfd_pkg::DB1_THERM] == $past(thermal_warn_in)) // see RULE10
        else $error("thermal warning not reported");
    sticky_a: assert property (read_open_s ##0 s.perm && !s.first_pend
        && s.latch[0][0] && !fault_in[0].sgnd && !fault_in[0].svcc
        |=> s.snap[0][amfd_pkg::CH_SGND]) // see RULE4
        else $error("removed fault dropped too early");
    offset_live_a: assert property (read_open_s ##0 s.perm && !s.first_pend
        && s.ib1[amfd_pkg::IB1_OFS_EN]
        |=> s.snap[1][amfd_pkg::CH_OPEN] == $past(fault_in[1].offset)) // see RULE6
        else $error("offset result not live");
    clip_sel_a: assert property (s.ib2[amfd_pkg::IB2_PIN_SEL] == 1'b0
        ##1 s.ib2[amfd_pkg::IB2_PIN_SEL] == 1'b0
        |-> clip_output_pin == $past(clip_in)) // see RULE19
        else $error("clip pin not showing clip detection");
endmodule // amfd_diag

// file: src/amfd_pkg.sv
// Constants, field positions and carrier types of the diagnosis readout
package amfd_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h6c; // Address byte 8'hd8 >> 1
    localparam int NUM_CH = 4;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [2:0] IDX_IB2 = 3'h1;
    localparam logic [7:0] IB1_RST = 8'h00;
    localparam logic [7:0] IB2_RST = 8'h00;
    // First instruction byte fields
    localparam int IB1_TIMING = 7;
    localparam int IB1_DIAG_EN = 6;
    localparam int IB1_OFS_EN = 5;
    // Second instruction byte fields
    localparam int IB2_PIN_SEL = 5;
    localparam int IB2_PLAY = 4;
    localparam int IB2_CUR_EN = 2;
    // Diagnostic byte fields
    localparam int DB1_THERM = 7;
    localparam int DB1_DONE = 6;
    localparam int DB2_OFS_ACT = 7;
    localparam int DB2_CUR_ACT = 6;
    localparam int DB3_PLAY = 7;
    localparam int DB3_DIAG = 6;
    localparam int CH_SGND = 0;
    localparam int CH_SVCC = 1;
    localparam int CH_OPEN = 2;

    // Raw analog comparator outputs of one channel
    typedef struct packed {
        logic sgnd;
        logic svcc;
        logic sload;
        logic open;
        logic offset;
        logic cur_low;
    } amfd_fault_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
    } amfd_bus_st_t;

    // Whole state of the block
    typedef struct packed {
        amfd_bus_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic [2:0] idx;
        logic sda_oe;
        logic scl_q;
        logic sda_q;
        logic [7:0] ib1;
        logic [7:0] ib2;
        logic [3:0][7:0] snap;
        logic [3:0][2:0] latch;
        logic [3:0] seen;
        logic done;
        logic perm;
        logic first_pend;
        logic clip_pin;
    } amfd_state_t;
endpackage

// file: sim/amfd_host.sv
// Host bus controller model for the serial diagnosis port
`timescale 1ns/1ps
module amfd_host (
    input wire logic mclk,
    input wire logic sda_w,
    output logic scl,
    output logic sda_drv,
    output logic rd_flag,
    output logic [31:0] rd_data
);
    // Lines idle high, pulled up when released
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
        rd_flag = 1'b0;
        rd_data = 32'h0;
    end
    // Wait falling edges of the system clock
    task automatic hw(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // One bit slot; data held well past the falling bus clock
    task automatic bit_io(input logic b, output logic v);
        hw(2);
        sda_drv = b;
        hw(2);
        scl = 1'b1;
        hw(3);
        v = sda_w;
        hw(1);
        scl = 1'b0;
    endtask
    // Eight bits then the acknowledge slot
    task automatic byte_io(input logic [7:0] b, input logic ak,
        output logic [7:0] v, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], v[i]);
        bit_io(ak, a);
    endtask
    // Start condition from idle lines
    task automatic start_c;
        sda_drv = 1'b1;
        scl = 1'b1;
        hw(4);
        sda_drv = 1'b0;
        hw(4);
        scl = 1'b0;
    endtask
    // Stop condition, lines left idle
    task automatic stop_c;
        hw(2);
        sda_drv = 1'b0;
        hw(2);
        scl = 1'b1;
        hw(4);
        sda_drv = 1'b1;
        hw(4);
    endtask
    // Address then two instruction bytes; a is the address ack
    task automatic wr(input logic [7:0] adr, input logic [7:0] b0,
        input logic [7:0] b1, output logic a);
        logic [7:0] v;
        logic a1;
        start_c;
        byte_io(adr, 1'b1, v, a);
        if (a == 1'b0)
        begin
            byte_io(b0, 1'b1, v, a1);
            byte_io(b1, 1'b1, v, a1);
        end
        stop_c;
    endtask
    // Read of four diagnostic bytes, last one not acknowledged
    task automatic rd;
        logic [7:0] v;
        logic a;
        start_c;
        byte_io(8'hd9, 1'b1, v, a);
        for (int k = 0; k < 4; k++)
        begin
            byte_io(8'hff, k == 3, v, a);
            rd_data[31 - 8 * k -: 8] = v;
        end
        stop_c;
        rd_flag = 1'b1;
        hw(1);
        rd_flag = 1'b0;
    endtask
endmodule // amfd_host

// file: sim/amfd_diag_bench.sv
// Self-checking bench of the diagnosis readout
`timescale 1ns/1ps
module amfd_diag_bench;
    logic mclk, reset, scl, sda_drv, sda_w, sda_out, sda_oe;
    logic thermal_warn_in, clip_in, acq_done, ak, t, clip_pin;
    logic rd_flag;
    logic [7:0] ib1, ib2;
    logic [31:0] rd_data;
    logic [32:0] note;
    logic [32:0] notes[$];
    amfd_pkg::amfd_fault_t [3:0] fault_in;
    int error_cnt, comparisons;
    // Open-drain data line with pull-up
    assign sda_w = sda_drv & ~sda_oe;
    amfd_diag amfd_diag_inst (.mclk(mclk), .reset(reset), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .fault_in(fault_in), .thermal_warn_in(thermal_warn_in),
        .clip_in(clip_in), .acq_done(acq_done),
        .first_instruction_byte(ib1), .second_instruction_byte(ib2),
        .clip_output_pin(clip_pin));
    amfd_host amfd_host_inst (.mclk(mclk), .sda_w(sda_w), .scl(scl),
        .sda_drv(sda_drv), .rd_flag(rd_flag), .rd_data(rd_data));
    // Clock, 4 ns period
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Note the expected bytes, then read; thermal input random, expected bit 31 follows it unless z
    task automatic rdx(input logic sk, input logic [31:0] e, input logic z);
        t = 1'($urandom);
        thermal_warn_in = t;
        notes.push_back({sk, z ? e : {t, e[30:0]}});
        amfd_host_inst.rd();
    endtask
    // Oldest note popped at each completed read, compared unless its skip bit is set
    always @(posedge mclk)
        if (rd_flag === 1'b1)
        begin
            note = notes.pop_front();
            if (note[32] == 1'b0)
                chk("diag bytes", rd_data, note[31:0]);
        end
    // Hang guard
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        $display("CHECK FAILED watchdog expected done seen hang");
        test_done();
    end
    // Main sequence
    initial
    begin
        reset = 1'b1;
        fault_in = '0;
        thermal_warn_in = 1'b0;
        clip_in = 1'b0;
        acq_done = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        void'($urandom(96751));
        repeat (16) @(posedge mclk);
        @(negedge mclk) reset = 1'b0;
        rdx(1'b0, 32'h10101010, 1'b0);
        amfd_host_inst.wr(8'hd0, 8'hff, 8'hff, ak);
        chk("foreign ack", ak, 1);
        chk("ib1 kept", ib1, 0);
        amfd_host_inst.wr(8'hd8, 8'h20, 8'h20, ak);
        chk("own ack", ak, 0);
        chk("ib1", ib1, 8'h20);
        chk("ib2", ib2, 8'h20);
        // Live offset on channel 2 reaches pin and readout
        @(negedge mclk) fault_in[2].offset = 1'b1;
        amfd_host_inst.hw(3);
        chk("pin offset", clip_pin, 1);
        rdx(1'b0, 32'h10901410, 1'b0);
        @(negedge mclk) fault_in[2].offset = 1'b0;
        amfd_host_inst.hw(3);
        chk("pin offset", clip_pin, 0);
        rdx(1'b0, 32'h10901010, 1'b0);
        // Short to ground stays one read after removal
        @(negedge mclk) fault_in[0].sgnd = 1'b1;
        rdx(1'b0, 32'h11901010, 1'b0);
        @(negedge mclk) fault_in[0].sgnd = 1'b0;
        rdx(1'b0, 32'h11901010, 1'b0);
        rdx(1'b0, 32'h10901010, 1'b0);
        // Ground and supply short on one channel
        @(negedge mclk) fault_in[1].sgnd = 1'b1;
        fault_in[1].svcc = 1'b1;
        rdx(1'b0, 32'h10911010, 1'b0);
        rdx(1'b0, 32'h10901010, 1'b0);
        @(negedge mclk) fault_in = '0;
        rdx(1'b1, 32'h0, 1'b0);
        // Turn-on diagnosis, one-shot then repetition timing
        @(negedge mclk) fault_in[0].sgnd = 1'b1;
        fault_in[0].svcc = 1'b1;
        fault_in[1].sgnd = 1'b1;
        fault_in[1].open = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            amfd_host_inst.wr(8'hd8, {m[0], 7'h40}, 8'h00, ak);
            rdx(1'b0, m ? 32'h0a014000 : 32'h0, m == 0);
            rdx(1'b0, 32'h0a014000, 1'b0);
        end
        // Pin follows the clip detector
        repeat (4)
        begin
            @(negedge mclk) clip_in = 1'($urandom);
            amfd_host_inst.hw(3);
            chk("pin clip", clip_pin, clip_in);
        end
        // Acquisition end switches to permanent reporting
        @(negedge mclk) fault_in = '0;
        acq_done = 1'b1;
        @(negedge mclk) acq_done = 1'b0;
        rdx(1'b1, 32'h0, 1'b0);
        rdx(1'b0, 32'h50105010, 1'b0);
        // Tweeter current check: unmute and play first, then stimulus
        amfd_host_inst.wr(8'hd8, 8'h06, 8'h14, ak);
        chk("ib2 play", ib2, 8'h14);
        @(negedge mclk) fault_in[3].cur_low = 1'b1;
        amfd_host_inst.hw(12);
        rdx(1'b0, 32'h10509030, 1'b0);
        rdx(1'b0, 32'h10509030, 1'b0);
        test_done();
    end
endmodule // amfd_diag_bench
